// ### src/pbr_regs.sv
// Interrupt mask, bus location and PHY status registers on an AHB-Lite slave
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/100ps

module pbr_regs
  import pbr_pkg::*;
(
  input  wire logic        hclk,          // Bus clock
  input  wire logic        hresetn,       // Async reset, active low
  input  wire logic        hsel,          // Slave select
  input  wire logic [11:0] haddr,         // Byte address
  input  wire logic [1:0]  htrans,        // Transfer type
  input  wire logic        hwrite,        // Write when high
  input  wire logic [2:0]  hsize,         // Transfer size
  input  wire logic [31:0] hwdata,        // Write data
  input  wire logic        hready,        // Bus ready in
  output logic      [31:0] hrdata,        // Read data
  output logic             hreadyout,     // Slave ready
  output logic             hresp,         // Response, always OKAY
  input  wire logic        root_port_configuration, // High: root port, low: endpoint
  input  wire logic [31:0] event_pulse,   // Event strobes, one per status bit
  input  wire logic [4:0]  device_number, // Assigned device number
  input  wire logic [7:0]  bus_number,    // Assigned bus number
  input  wire logic [1:0]  link_rate,     // Rate code, async
  input  wire logic [2:0]  link_width,    // Width code 0..4, async
  input  wire logic [5:0]  ltssm_state,   // Training state code, async
  output logic      [7:0]  port_number,   // Port number for link capabilities
  output logic             irq            // Combined interrupt line
);

  // ----------------------------------------------------------------
  // Address phase capture
  // ----------------------------------------------------------------
  logic        wr_pend_q;
  logic        wr_pend_d;
  logic [11:0] addr_q;
  logic [11:0] addr_d;
  logic        rd_pend_q;
  logic        rd_pend_d;
  wire         accept = hsel & hready & htrans[PBR_HTRANS_NONSEQ_BIT];

  assign wr_pend_d = accept & hwrite;
  assign rd_pend_d = accept & ~hwrite;
  assign addr_d    = accept ? haddr : addr_q;

  // Capture address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 12'h000;
    end else begin
      wr_pend_q <= wr_pend_d;
      rd_pend_q <= rd_pend_d;
      addr_q    <= addr_d;
    end
  end

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  wire wr_mask = wr_pend_q & (addr_q == PBR_OFF_MASK);
  wire wr_loc  = wr_pend_q & (addr_q == PBR_OFF_LOCATION);
  wire wr_stat = wr_pend_q & (addr_q == PBR_OFF_STATUS);

  // ----------------------------------------------------------------
  // Interrupt mask register
  // ----------------------------------------------------------------
  logic [31:0] mask_q;
  logic [31:0] mask_d;
  wire  [31:0] mask_wr_en = PBR_MASK_WR_ANY
                          | (root_port_configuration ? PBR_MASK_WR_RP : PBR_MASK_WR_EP);
  // INTx and MSI enables gated likewise
  assign mask_d = wr_mask ? (hwdata & mask_wr_en) : (mask_q & mask_wr_en);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q <= PBR_MASK_RESET;
    end else begin
      mask_q <= mask_d;
    end
  end

  // ----------------------------------------------------------------
  // Event status register
  // ----------------------------------------------------------------
  logic [31:0] stat_q;
  logic [31:0] stat_d;
  wire  [31:0] w1c = wr_stat ? hwdata : 32'h0000_0000;
  assign stat_d = ((stat_q & ~w1c) | event_pulse) & PBR_EVT_BITS;

  // Status storage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= 32'h0000_0000;
    end else begin
      stat_q <= stat_d;
    end
  end

  // Each source gated by its mask
  assign irq = |(stat_q & mask_q & ~PBR_MASK_NOFUNC);

  // ----------------------------------------------------------------
  // Bus location register
  // ----------------------------------------------------------------
  logic [7:0] port_q;
  logic [7:0] port_d;
  // Port number writable only as root port
  assign port_d = !root_port_configuration ? 8'h00 :
                  wr_loc ? hwdata[PBR_LOC_PORT_LSB +: 8] : port_q;

  // Port number storage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_q <= 8'h00;
    end else begin
      port_q <= port_d;
    end
  end
  assign port_number = port_q;

  // Function zero; device and bus read-only
  wire [31:0] loc_word = {8'h00, port_q, bus_number, device_number, 3'h0};

  // ----------------------------------------------------------------
  // PHY status: synchronise link-side inputs
  // ----------------------------------------------------------------
  logic [10:0] phy_s1_q;
  logic [10:0] phy_s2_q;
  logic [10:0] phy_s3_q;
  logic [10:0] phy_hold_q;

  // Bits of one word may resolve in different cycles; take it only once settled
  wire phy_stable = (phy_s2_q == phy_s3_q);

  // Two-stage synchroniser, then a stability filter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phy_s1_q   <= 11'h000;
      phy_s2_q   <= 11'h000;
      phy_s3_q   <= 11'h000;
      phy_hold_q <= 11'h000;
    end else begin
      phy_s1_q   <= {link_rate, link_width, ltssm_state};
      phy_s2_q   <= phy_s1_q;
      phy_s3_q   <= phy_s2_q;
      phy_hold_q <= phy_stable ? phy_s2_q : phy_hold_q;
    end
  end

  // Fields of the settled word
  wire [5:0] st_ltssm = phy_hold_q[5:0];
  wire [2:0] st_width = phy_hold_q[8:6];
  wire [1:0] st_rate  = phy_hold_q[10:9];

  wire       rate_g3 = (st_rate == PBR_RATE_8G0);
  wire       rate_g2 = (st_rate == PBR_RATE_5G0);
  wire       wid_x16 = (st_width == PBR_WIDTH_X16);
  wire [1:0] wid_enc = wid_x16 ? 2'h3 : st_width[1:0];
  wire       link_up = (st_ltssm == PBR_LTSSM_L0);

  logic [31:0] phy_word;
  always_comb begin
    phy_word = 32'h0000_0000;
    phy_word[PBR_PHY_GEN2_BIT]          = rate_g2;
    phy_word[PBR_PHY_WID_LSB +: 2]      = wid_enc;
    phy_word[PBR_PHY_LTSSM_LSB +: 6]    = st_ltssm;
    phy_word[PBR_PHY_UP_BIT]            = link_up;
    phy_word[PBR_PHY_GEN3_BIT]          = rate_g3;
    phy_word[PBR_PHY_X16_BIT]           = wid_x16;
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  assign rdata_d = !rd_pend_d                 ? rdata_q :
                   (haddr == PBR_OFF_MASK)     ? mask_q :
                   (haddr == PBR_OFF_LOCATION) ? loc_word :
                   (haddr == PBR_OFF_PHY)      ? phy_word :
                   (haddr == PBR_OFF_STATUS)   ? stat_q : 32'h0000_0000;

  // Read data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign hrdata = rdata_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_irq_gated: assert property (@(posedge hclk) disable iff (!hresetn)
    irq |-> |(stat_q & mask_q)) else $error("irq without enabled source");

  a_mask_reset: assert property (@(posedge hclk)
    !hresetn |=> (mask_q == 32'h0000_0000) || !hresetn) else $error("mask not cleared");

  a_mask_bit0_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_mask |=> mask_q[0] == $past(hwdata[0])) else $error("mask bit 0 write lost");

  a_hot_reset_ep: assert property (@(posedge hclk) disable iff (!hresetn)
    root_port_configuration |=> !mask_q[3]) else $error("mask bit 3 set as root port");

  a_rp_bits_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    !root_port_configuration |=> (mask_q & PBR_MASK_WR_RP) == 32'h0000_0000)
    else $error("root port enables set as endpoint");

  a_err_bits_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_mask && root_port_configuration) |=> mask_q[11:8] == $past(hwdata[11:8]))
    else $error("error enables write lost");

  a_msi_bits_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_mask && root_port_configuration) |=> mask_q[17:16] == $past(hwdata[17:16]))
    else $error("INTx or MSI enable write lost");

  a_slave_bits_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_mask |=> mask_q[25:20] == $past(hwdata[25:20])) else $error("slave enable write lost");

  a_master_bits: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_mask |=> mask_q[27:26] == $past(hwdata[27:26])) else $error("master enable write lost");

  a_bit22_nofunc: assert property (@(posedge hclk) disable iff (!hresetn)
    (stat_q & mask_q & ~PBR_MASK_NOFUNC) == 32'h0000_0000 |-> !irq)
    else $error("bit 22 drives irq");

  a_loc_func_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_pend_q && addr_q == PBR_OFF_LOCATION) |-> hrdata[2:0] == 3'h0)
    else $error("function number not zero");

  a_port_ep_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    !root_port_configuration |=> port_number == 8'h00) else $error("port number as endpoint");

  a_link_up_l0: assert property (@(posedge hclk) disable iff (!hresetn)
    phy_word[PBR_PHY_UP_BIT] == (phy_word[8:3] == PBR_LTSSM_L0)) else $error("link up mismatch");

  a_status_set: assert property (@(posedge hclk) disable iff (!hresetn)
    event_pulse[0] |=> stat_q[0]) else $error("event lost under clear");

  // ----------------------------------------------------------------
  // Further checks on fields and read paths
  // ----------------------------------------------------------------
  // Device and bus fields follow the inputs
  a_loc_dev_bus: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_pend_q && addr_q == PBR_OFF_LOCATION) |-> hrdata[15:3] == $past({bus_number, device_number}))
    else $error("device or bus number wrong");

  // Top byte of location reads zero
  a_loc_top_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_pend_q && addr_q == PBR_OFF_LOCATION) |-> hrdata[31:24] == 8'h00)
    else $error("location top byte not zero");

  // Port field reads the stored number
  a_loc_port_rd: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_pend_q && addr_q == PBR_OFF_LOCATION) |-> hrdata[23:16] == $past(port_q))
    else $error("port number read wrong");

  // Port number written as root port
  a_port_rp_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_loc && root_port_configuration) |=> port_number == $past(hwdata[23:16]))
    else $error("port number write lost");

  // Reserved mask positions never set
  a_mask_rsvd: assert property (@(posedge hclk) disable iff (!hresetn)
    (mask_q & ~(PBR_MASK_WR_ANY | PBR_MASK_WR_RP | PBR_MASK_WR_EP)) == 32'h0000_0000)
    else $error("reserved mask bit set");

  // Hot-reset enable written as endpoint
  a_mask_ep_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_mask && !root_port_configuration) |=> mask_q[3] == $past(hwdata[3]))
    else $error("hot reset enable write lost");

  // Completion-status enables written as root port
  a_cpl_bits_wr: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_mask && root_port_configuration) |=> mask_q[7:5] == $past(hwdata[7:5]))
    else $error("completion enables write lost");

  // Bit 22 keeps what was written
  a_bit22_store: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_mask |=> mask_q[22] == $past(hwdata[22]))
    else $error("bit 22 storage lost");

  // Any enabled source raises the line
  a_irq_source: assert property (@(posedge hclk) disable iff (!hresetn)
    (|(stat_q & mask_q & ~PBR_MASK_NOFUNC)) |-> irq)
    else $error("enabled source without irq");

  // Writing one clears a status bit when no event
  a_stat_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_stat && hwdata[0] && !event_pulse[0]) |=> !stat_q[0])
    else $error("status bit not cleared");

  // Status bits outside the event set stay zero
  a_stat_rsvd: assert property (@(posedge hclk) disable iff (!hresetn)
    (stat_q & ~PBR_EVT_BITS) == 32'h0000_0000)
    else $error("reserved status bit set");

  // Only one rate flag at a time
  a_phy_rate: assert property (@(posedge hclk) disable iff (!hresetn)
    phy_word[PBR_PHY_GEN3_BIT] |-> !phy_word[PBR_PHY_GEN2_BIT])
    else $error("two rate flags set");

  // Narrow widths shown on bits 2:1
  a_phy_width: assert property (@(posedge hclk) disable iff (!hresetn)
    !phy_word[PBR_PHY_X16_BIT] |-> phy_word[2:1] == st_width[1:0])
    else $error("width code wrong");

  // Training state shown unchanged
  a_phy_ltssm: assert property (@(posedge hclk) disable iff (!hresetn)
    phy_word[8:3] == st_ltssm)
    else $error("training state field wrong");

  // Reserved status positions read zero
  a_phy_rsvd: assert property (@(posedge hclk) disable iff (!hresetn)
    (phy_word & 32'hFFFF_C600) == 32'h0000_0000)
    else $error("reserved phy bit set");

  // PHY read returns the word of the address phase
  a_phy_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_pend_q && addr_q == PBR_OFF_PHY) |-> hrdata == $past(phy_word))
    else $error("phy read data wrong");

  // Unmapped reads return zero
  a_unmapped_rd: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_pend_q && addr_q != PBR_OFF_MASK && addr_q != PBR_OFF_LOCATION
     && addr_q != PBR_OFF_PHY && addr_q != PBR_OFF_STATUS) |-> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");

endmodule

// ### pkg/pbr_pkg.sv
// Package: offsets, field layouts and masks of the bridge status register bank
package pbr_pkg;

  // Register byte offsets
  localparam logic [11:0] PBR_OFF_STATUS   = 12'h138;
  localparam logic [11:0] PBR_OFF_MASK     = 12'h13C;
  localparam logic [11:0] PBR_OFF_LOCATION = 12'h140;
  localparam logic [11:0] PBR_OFF_PHY      = 12'h144;

  // Mask register reset value
  localparam logic [31:0] PBR_MASK_RESET   = 32'h0000_0000;

  // Mask bits writable in every configuration: 0, 20..27
  localparam logic [31:0] PBR_MASK_WR_ANY  = 32'h0FF0_0001;
  // Mask bit writable only as endpoint: 3
  localparam logic [31:0] PBR_MASK_WR_EP   = 32'h0000_0008;
  // Mask bits writable only as root port: 5..11, 16, 17
  localparam logic [31:0] PBR_MASK_WR_RP   = 32'h0003_0FE0;
  // Mask bits without an interrupt function: 22
  localparam logic [31:0] PBR_MASK_NOFUNC  = 32'h0040_0000;
  // Event status bits that exist
  localparam logic [31:0] PBR_EVT_BITS     = 32'h0FB3_0FE9;

  // Location register fields
  localparam int PBR_LOC_DEV_LSB  = 3;
  localparam int PBR_LOC_BUS_LSB  = 8;
  localparam int PBR_LOC_PORT_LSB = 16;

  // PHY status fields
  localparam int PBR_PHY_GEN2_BIT  = 0;
  localparam int PBR_PHY_WID_LSB   = 1;
  localparam int PBR_PHY_LTSSM_LSB = 3;
  localparam int PBR_PHY_UP_BIT    = 11;
  localparam int PBR_PHY_GEN3_BIT  = 12;
  localparam int PBR_PHY_X16_BIT   = 13;

  // Link rate and width codes on the link-side inputs
  typedef enum logic [1:0] {PBR_RATE_2G5, PBR_RATE_5G0, PBR_RATE_8G0} pbr_rate_t;
  localparam logic [2:0] PBR_WIDTH_X16 = 3'h4;

  // LTSSM code of L0
  localparam logic [5:0] PBR_LTSSM_L0 = 6'h10;

  // AHB transfer type NONSEQ bit
  localparam int PBR_HTRANS_NONSEQ_BIT = 1;

endpackage

// ### test/pbr_link_model.sv
// Link partner model presenting PHY state and event strobes
`timescale 1ns/100ps

module pbr_link_model (
  input  wire logic        hclk,        // Bus clock
  input  wire logic [1:0]  rate_req,    // Rate to present
  input  wire logic [2:0]  width_req,   // Width to present
  input  wire logic [5:0]  state_req,   // Training state to present
  input  wire logic [31:0] evt_req,     // Events to fire
  output logic      [1:0]  link_rate,   // Rate code
  output logic      [2:0]  link_width,  // Width code
  output logic      [5:0]  ltssm_state, // Training state code
  output logic      [31:0] event_pulse  // Event strobes
);
  // Link side moves one edge after a request, like a far clock domain
  always_ff @(posedge hclk) begin
    link_rate   <= rate_req;
    link_width  <= width_req;
    ltssm_state <= state_req;
    event_pulse <= evt_req;
  end
endmodule

// ### test/test_pbr_regs.sv
// Self-checking bench for the bridge register bank
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end

module test_pbr_regs
  import pbr_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, rpc, dph, hreadyout, hresp, irq;
  logic [11:0] haddr;
  logic [1:0]  htrans, rate, link_rate;
  logic [2:0]  width, link_width;
  logic [5:0]  st, ltssm_state;
  logic [4:0]  dev;
  logic [7:0]  bus, port_number;
  logic [31:0] hwdata, hrdata, evt, event_pulse, r, al, m;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int          error_cnt, tests_run;

  pbr_regs pbr_regs_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .root_port_configuration(rpc),
    .event_pulse(event_pulse), .device_number(dev), .bus_number(bus),
    .link_rate(link_rate), .link_width(link_width), .ltssm_state(ltssm_state),
    .port_number(port_number), .irq(irq));
  pbr_link_model pbr_link_model_inst (.hclk(hclk), .rate_req(rate), .width_req(width),
    .state_req(st), .evt_req(evt), .link_rate(link_rate), .link_width(link_width),
    .ltssm_state(ltssm_state), .event_pulse(event_pulse));

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // Read data checked against the oldest note at the end of each data phase
  always @(posedge hclk) begin
    if (dph) begin
      `CHK(hrdata & msk_q[0], exp_q[0])
      `CHK(hresp, 1'b0)
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    dph <= hsel && htrans[1] && !hwrite && hreadyout;
  end

  task summarize();
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Waits for an edge with hready high, bounded
  task automatic wrdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      error_cnt++;
      summarize();
    end
  endtask

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wrdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wrdy();
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] k);
    exp_q.push_back(e & k);
    msk_q.push_back(k);
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic cirq(input logic e);
    @(posedge hclk);
    `CHK(irq, e)
  endtask

  task automatic fire(input int b);
    evt <= 32'h1 << b;
    @(posedge hclk);
    evt <= 32'h0;
    repeat (3) @(posedge hclk);
  endtask

  function automatic logic [31:0] phy_e(input int rr, input int w, input logic [5:0] s);
    phy_e = 32'h0;
    phy_e[0] = (rr == 1);
    phy_e[12] = (rr == 2);
    phy_e[13] = (w == 4);
    phy_e[2:1] = w[1:0];
    phy_e[8:3] = s;
    phy_e[11] = (s == PBR_LTSSM_L0);
  endfunction

  initial begin
    void'($urandom(58863));
    dev = 5'($urandom());
    bus = 8'($urandom());
    {hresetn, hsel, hwrite, rpc, haddr, htrans, hwdata, evt} = '0;
    {rate, width, st} = '0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd(PBR_OFF_MASK, PBR_MASK_RESET, '1);
    rd(PBR_OFF_LOCATION, {16'h0, bus, dev, 3'h0}, '1);
    rd(12'h200, 32'h0, '1);
    cirq(1'b0);
    $display("test reset values done");
    // Writable mask bits and port number per configuration
    for (int c = 0; c < 2; c++) begin
      rpc <= c[0];
      al = PBR_MASK_WR_ANY | (c ? PBR_MASK_WR_RP : PBR_MASK_WR_EP);
      for (int i = 0; i < 4; i++) begin
        r = (i == 0) ? 32'hFFFF_FFFF : $urandom();
        wr_both(r);
        rd(PBR_OFF_MASK, r & al, '1);
        rd(PBR_OFF_LOCATION, {8'h0, c ? r[23:16] : 8'h0, bus, dev, 3'h0}, '1);
        `CHK(port_number, c ? r[23:16] : 8'h0)
      end
    end
    $display("test writable bits done");
    // Each event with its mask off, then on, then cleared
    for (int c = 0; c < 2; c++) begin
      rpc <= c[0];
      al = PBR_MASK_WR_ANY | (c ? PBR_MASK_WR_RP : PBR_MASK_WR_EP);
      for (int b = 0; b < 32; b++) begin
        m = 32'h1 << b;
        xfer(1'b1, PBR_OFF_MASK, 32'h0);
        fire(b);
        cirq(1'b0);
        rd(PBR_OFF_STATUS, PBR_EVT_BITS, al & m);
        xfer(1'b1, PBR_OFF_MASK, m);
        cirq(|(al & m & PBR_EVT_BITS & ~PBR_MASK_NOFUNC));
        xfer(1'b1, PBR_OFF_STATUS, m);
        cirq(1'b0);
        rd(PBR_OFF_STATUS, 32'h0, m);
      end
    end
    $display("test interrupt gating done");
    // Every rate and width code with a training state
    for (int i = 0; i < 3; i++) begin
      for (int w = 0; w < 5; w++) begin
        rate <= i[1:0];
        width <= w[2:0];
        st <= (w == 2) ? PBR_LTSSM_L0 : 6'($urandom());
        repeat (6) @(posedge hclk);
        rd(PBR_OFF_PHY, phy_e(i, w, st), (w == 4) ? 32'hFFFF_FFF9 : '1);
      end
    end
    $display("test phy status done");
    wr_both(32'hFFFF_FFFF);
    rd(PBR_OFF_MASK, PBR_MASK_WR_ANY | PBR_MASK_WR_RP, '1);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    rd(PBR_OFF_MASK, 32'h0, '1);
    `CHK(port_number, 8'h00)
    cirq(1'b0);
    $display("test second reset done");
    summarize();
  end

  task automatic wr_both(input logic [31:0] d);
    xfer(1'b1, PBR_OFF_MASK, d);
    xfer(1'b1, PBR_OFF_LOCATION, d);
  endtask
endmodule
